// ==== src/csr_bank.sv ====
// card status word and relative card address register bank
module csr_bank
   import csr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic spi_mode,
   input wire logic cmd_rx,
   input wire logic cmd_crc_bad,
   input wire logic cmd_illegal,
   input wire logic [CSR_FLAG_N-1:0] cmd_err_ev,
   input wire logic [CSR_FLAG_N-1:0] exec_err_ev,
   input wire logic [CSR_STATE_W-1:0] card_state,
   input wire logic ecc_off,
   input wire logic buf_ready,
   input wire logic rca_load,
   input wire logic [CSR_RCA_W-1:0] rca_in,
   output logic resp_valid,
   output logic [CSR_WORD_W-1:0] resp_word,
   output logic [CSR_RCA_W-1:0] rca_out
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic crc_fault;
      logic bad_cmd_for_state;
      logic resp_valid;
      logic [CSR_WORD_W-1:0] resp_word;
      logic [CSR_RCA_W-1:0] relative_card_address;
      logic [CSR_RCA_W-1:0] rca_out;
   } csr_bank_st_t;

   csr_bank_st_t st_r;
   csr_bank_st_t st_nxt;
   logic [CSR_FLAG_N-1:0] cflag;
   logic cmd_ok;
   logic status_read;
   logic [CSR_WORD_W-1:0] word_now;

   assign cmd_ok = cmd_rx & ~cmd_crc_bad & ~cmd_illegal;
   // a valid response carries the status, which is the read that clears
   assign status_read = cmd_ok & ~spi_mode;

   // ****************************************
   // clear-by-read flags
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < CSR_FLAG_N; gi++) begin : g_flag
         csr_flag u_flag (
            .clk(clk),
            .rst_b(rst_b),
            .ce(ce),
            .set(exec_err_ev[gi]),
            .clr(status_read),
            .q(cflag[gi])
         );
      end
   endgenerate

   // ****************************************
   // status word assembly
   // ****************************************
   always_comb begin
      word_now = CSR_WORD_RST;
      for (int i = 0; i < CSR_FLAG_N; i++) begin
         word_now[CSR_FLAG_POS[i]] = cflag[i] | cmd_err_ev[i];
      end
      word_now[CSR_POS_CRC] = st_r.crc_fault;
      word_now[CSR_POS_ILLEGAL] = st_r.bad_cmd_for_state;
      word_now[CSR_POS_ECCOFF] = ecc_off;
      word_now[CSR_POS_STATE_LSB +: CSR_STATE_W] = card_state;
      word_now[CSR_POS_READY] = buf_ready;
      word_now = word_now & ~CSR_ZERO_MASK;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      if (ce) begin
         st_nxt.resp_valid = status_read;
         if (status_read) begin
            st_nxt.resp_word = word_now;
         end
         if (cmd_rx) begin
            st_nxt.crc_fault = cmd_crc_bad;
            st_nxt.bad_cmd_for_state = cmd_illegal & ~cmd_crc_bad;
         end
         if (rca_load) begin
            st_nxt.relative_card_address = rca_in;
         end
         st_nxt.rca_out = spi_mode ? CSR_RCA_RST : st_nxt.relative_card_address;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{crc_fault: 1'b0, bad_cmd_for_state: 1'b0, resp_valid: 1'b0,
                   resp_word: CSR_WORD_RST, relative_card_address: CSR_RCA_RST,
                   rca_out: CSR_RCA_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign resp_valid = st_r.resp_valid;
   assign resp_word = st_r.resp_word;
   assign rca_out = st_r.rca_out;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_resp_same_cmd: assert property (
      ce && status_read && cmd_err_ev[CSR_IX_RANGE] |=> resp_valid && resp_word[CSR_POS_RANGE])
      else $error("response-time error missing from own response");

   a_exec_flag_sticky: assert property (
      ce && exec_err_ev[CSR_IX_ADDR]
      |=> cflag[CSR_IX_ADDR] ##1 (cflag[CSR_IX_ADDR] || $past(ce && status_read)))
      else $error("execution error flag did not latch");

   a_range_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_RANGE] |=> !cflag[CSR_IX_RANGE])
      else $error("range fault not cleared by read");

   a_addr_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_ADDR] |=> !cflag[CSR_IX_ADDR])
      else $error("address fault not cleared by read");

   a_blklen_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_BLKLEN] |=> !cflag[CSR_IX_BLKLEN])
      else $error("block length fault not cleared by read");

   a_erseq_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_ERSEQ] |=> !cflag[CSR_IX_ERSEQ])
      else $error("erase order fault not cleared by read");

   a_ersel_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_ERSEL] |=> !cflag[CSR_IX_ERSEL])
      else $error("erase select fault not cleared by read");

   a_wprog_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_WPROG] |=> !cflag[CSR_IX_WPROG])
      else $error("protected program fault not cleared by read");

   a_general_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_GENERAL] |=> !cflag[CSR_IX_GENERAL])
      else $error("general fault not cleared by read");

   a_rewrite_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_REWRITE] |=> !cflag[CSR_IX_REWRITE])
      else $error("rewrite fault not cleared by read");

   a_wpskip_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_WPSKIP] |=> !cflag[CSR_IX_WPSKIP])
      else $error("erase skip flag not cleared by read");

   a_erreset_read_clear: assert property (
      ce && status_read && !exec_err_ev[CSR_IX_ERRESET] |=> !cflag[CSR_IX_ERRESET])
      else $error("erase abandon flag not cleared by read");

   a_range_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_RANGE] ##1 ce && status_read |=> resp_word[CSR_POS_RANGE])
      else $error("range fault missing from next response");

   a_addr_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_ADDR] ##1 ce && status_read |=> resp_word[CSR_POS_ADDR])
      else $error("address fault missing from next response");

   a_blklen_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_BLKLEN] ##1 ce && status_read |=> resp_word[CSR_POS_BLKLEN])
      else $error("block length fault missing from next response");

   a_erseq_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_ERSEQ] ##1 ce && status_read |=> resp_word[CSR_POS_ERSEQ])
      else $error("erase order fault missing from next response");

   a_ersel_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_ERSEL] ##1 ce && status_read |=> resp_word[CSR_POS_ERSEL])
      else $error("erase select fault missing from next response");

   a_wprog_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_WPROG] ##1 ce && status_read |=> resp_word[CSR_POS_WPROG])
      else $error("protected program fault missing from next response");

   a_general_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_GENERAL] ##1 ce && status_read |=> resp_word[CSR_POS_GENERAL])
      else $error("general fault missing from next response");

   a_rewrite_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_REWRITE] ##1 ce && status_read |=> resp_word[CSR_POS_REWRITE])
      else $error("rewrite fault missing from next response");

   a_wpskip_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_WPSKIP] ##1 ce && status_read |=> resp_word[CSR_POS_WPSKIP])
      else $error("erase skip flag missing from next response");

   a_erreset_set_shown: assert property (
      ce && exec_err_ev[CSR_IX_ERRESET] ##1 ce && status_read |=> resp_word[CSR_POS_ERRESET])
      else $error("erase abandon flag missing from next response");

   a_prev_cmd_clear: assert property (
      ce && cmd_ok |=> !st_r.crc_fault && !st_r.bad_cmd_for_state)
      else $error("previous-command flags not cleared by valid command");

   a_crc_sets_only: assert property (
      ce && cmd_rx && cmd_crc_bad |=> st_r.crc_fault && !st_r.bad_cmd_for_state)
      else $error("crc failure did not set only the crc flag");

   a_crc_next_resp: assert property (
      ce && cmd_rx && cmd_crc_bad ##1 (ce && status_read) |=> resp_word[CSR_POS_CRC])
      else $error("crc fault not shown in next response");

   a_illegal_flag_set: assert property (
      ce && cmd_rx && cmd_illegal && !cmd_crc_bad |=> st_r.bad_cmd_for_state && !st_r.crc_fault)
      else $error("bad_cmd_for_state did not set its flag");

   a_illegal_no_resp: assert property (
      ce && cmd_rx && cmd_illegal && !cmd_crc_bad
      |=> !resp_valid and (ce && status_read |=> resp_word[CSR_POS_ILLEGAL]))
      else $error("bad_cmd_for_state answered or not reported next");

   a_state_at_arrival: assert property (
      ce && status_read |=> resp_word[CSR_POS_STATE_LSB +: CSR_STATE_W] == $past(card_state)
         && resp_word[CSR_POS_ECCOFF] == $past(ecc_off)
         && resp_word[CSR_POS_READY] == $past(buf_ready))
      else $error("state-following bits do not match arrival values");

   a_resp_one_cycle: assert property (
      ce && !status_read |=> !resp_valid)
      else $error("response strobe without a valid command");

   a_word_hold: assert property (
      ce && !status_read |=> $stable(resp_word))
      else $error("response word changed without a response");

   a_zero_bits: assert property (
      (resp_word & CSR_ZERO_MASK) == CSR_WORD_RST)
      else $error("unused status bits not zero");

   a_rca_load: assert property (
      ce && rca_load && !spi_mode |=> rca_out == $past(rca_in))
      else $error("relative address not loaded");

   a_rca_hold: assert property (
      ce && !rca_load |=> st_r.relative_card_address == $past(st_r.relative_card_address))
      else $error("relative address changed without a load");

   a_output_freeze: assert property (
      !ce |=> $stable(resp_valid) && $stable(resp_word) && $stable(rca_out))
      else $error("outputs moved while clock enable low");

   a_flag_freeze: assert property (
      !ce |=> $stable(cflag) && $stable(st_r.crc_fault) && $stable(st_r.bad_cmd_for_state))
      else $error("flags moved while clock enable low");

   a_spi_hidden: assert property (
      ce && spi_mode |=> !resp_valid && rca_out == CSR_RCA_RST)
      else $error("long status or address visible in spi mode");

   a_spi_keeps_flags: assert property (
      ce && spi_mode && exec_err_ev == '0 |=> cflag == $past(cflag))
      else $error("sticky flags cleared in spi mode");

   c_valid_resp: cover property (ce && status_read ##1 resp_valid);
   c_crc_then_ok: cover property (ce && cmd_rx && cmd_crc_bad ##[1:4] ce && status_read);
   c_exec_then_read: cover property (ce && exec_err_ev[CSR_IX_GENERAL] ##[1:8] ce && status_read);
   c_illegal_then_ok: cover property (ce && cmd_rx && cmd_illegal && !cmd_crc_bad ##1 ce && status_read);
   c_spi_cmd: cover property (ce && spi_mode && cmd_rx);

endmodule

// ==== src/csr_flag.sv ====
// one sticky status flag, set wins over clear
module csr_flag
   import csr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic set,
   input wire logic clr,
   output logic q
);

   typedef struct packed {
      logic q;
   } csr_flag_st_t;

   csr_flag_st_t st_r;
   csr_flag_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (ce) begin
         if (set) begin
            st_nxt.q = 1'b1;
         end else if (clr) begin
            st_nxt.q = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{q: CSR_FLAG_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.q;

endmodule

// ==== src/csr_pkg.sv ====
// constants for the card status word and relative address register
package csr_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int CSR_WORD_W = 32;
   localparam int CSR_RCA_W = 16;
   localparam int CSR_STATE_W = 4;
   localparam int CSR_FLAG_N = 10;

   // ****************************************
   // clear-by-read flag indices into event vectors
   // ****************************************
   localparam int CSR_IX_RANGE = 0;
   localparam int CSR_IX_ADDR = 1;
   localparam int CSR_IX_BLKLEN = 2;
   localparam int CSR_IX_ERSEQ = 3;
   localparam int CSR_IX_ERSEL = 4;
   localparam int CSR_IX_WPROG = 5;
   localparam int CSR_IX_GENERAL = 6;
   localparam int CSR_IX_REWRITE = 7;
   localparam int CSR_IX_WPSKIP = 8;
   localparam int CSR_IX_ERRESET = 9;

   // ****************************************
   // bit positions in the status word
   // ****************************************
   localparam int CSR_POS_RANGE = 31;
   localparam int CSR_POS_ADDR = 30;
   localparam int CSR_POS_BLKLEN = 29;
   localparam int CSR_POS_ERSEQ = 28;
   localparam int CSR_POS_ERSEL = 27;
   localparam int CSR_POS_WPROG = 26;
   localparam int CSR_POS_CRC = 23;
   localparam int CSR_POS_ILLEGAL = 22;
   localparam int CSR_POS_GENERAL = 19;
   localparam int CSR_POS_REWRITE = 16;
   localparam int CSR_POS_WPSKIP = 15;
   localparam int CSR_POS_ECCOFF = 14;
   localparam int CSR_POS_ERRESET = 13;
   localparam int CSR_POS_STATE_LSB = 9;
   localparam int CSR_POS_READY = 8;

   localparam int CSR_FLAG_POS [CSR_FLAG_N] = '{
      CSR_POS_RANGE, CSR_POS_ADDR, CSR_POS_BLKLEN, CSR_POS_ERSEQ, CSR_POS_ERSEL,
      CSR_POS_WPROG, CSR_POS_GENERAL, CSR_POS_REWRITE, CSR_POS_WPSKIP, CSR_POS_ERRESET};

   // bits 25-24, 21-20, 18, 17, 7-0 always zero
   localparam logic [CSR_WORD_W-1:0] CSR_ZERO_MASK = 32'h033600ff;

   // ****************************************
   // state codes and reset values
   // ****************************************
   localparam logic [CSR_STATE_W-1:0] CSR_ST_IDLE = 4'h0;
   localparam logic [CSR_STATE_W-1:0] CSR_ST_READY = 4'h1;
   localparam logic [CSR_STATE_W-1:0] CSR_ST_IDENT = 4'h2;
   localparam logic [CSR_STATE_W-1:0] CSR_ST_STBY = 4'h3;
   localparam logic [CSR_STATE_W-1:0] CSR_ST_TRAN = 4'h4;
   localparam logic [CSR_STATE_W-1:0] CSR_ST_DATA = 4'h5;
   localparam logic [CSR_STATE_W-1:0] CSR_ST_RCV = 4'h6;
   localparam logic [CSR_STATE_W-1:0] CSR_ST_PRG = 4'h7;
   localparam logic [CSR_STATE_W-1:0] CSR_ST_DIS = 4'h8;

   localparam logic [CSR_WORD_W-1:0] CSR_WORD_RST = 32'h00000000;
   localparam logic [CSR_RCA_W-1:0] CSR_RCA_RST = 16'h0000;
   localparam logic CSR_FLAG_RST = 1'b0;

endpackage

// ==== verification/csr_bank_tb.sv ====
// self-checking bench for the card status bank
module csr_bank_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import csr_pkg::*;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
   logic clk, rst_b, ce, spi_mode, go, crc, ill, ecc_off, buf_ready, rca_load;
   logic cmd_rx, cmd_crc_bad, cmd_illegal, resp_valid, m_crc, m_ill, m_spi, m_ce;
   logic [CSR_FLAG_N-1:0] ev, xev, cev;
   logic [CSR_STATE_W-1:0] card_state;
   logic [CSR_RCA_W-1:0] rca_in, rca_out, m_rca;
   logic [CSR_WORD_W-1:0] resp_word, m_stk, w, g;
   logic [CSR_WORD_W-1:0] q[$];
   int mismatches, compares;
   // ****************************************
   // instances
   // ****************************************
   csr_host i_csr_host (.go(go), .crc_i(crc), .ill_i(ill), .ev_i(ev), .cmd_rx(cmd_rx),
      .cmd_crc_bad(cmd_crc_bad), .cmd_illegal(cmd_illegal), .cmd_err_ev(cev));
   csr_bank i_csr_bank (.clk(clk), .rst_b(rst_b), .ce(ce), .spi_mode(spi_mode),
      .cmd_rx(cmd_rx), .cmd_crc_bad(cmd_crc_bad), .cmd_illegal(cmd_illegal),
      .cmd_err_ev(cev), .exec_err_ev(xev), .card_state(card_state), .ecc_off(ecc_off),
      .buf_ready(buf_ready), .rca_load(rca_load), .rca_in(rca_in),
      .resp_valid(resp_valid), .resp_word(resp_word), .rca_out(rca_out));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [CSR_WORD_W-1:0] place(input logic [CSR_FLAG_N-1:0] v);
      logic [CSR_WORD_W-1:0] r;
      r = '0;
      for (int i = 0; i < CSR_FLAG_N; i++) r[CSR_FLAG_POS[i]] = v[i];
      return r;
   endfunction
   task automatic finish_test;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ****************************************
   // reference model, notes expected words
   // ****************************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         m_stk = '0;
         m_crc = 1'b0;
         m_ill = 1'b0;
         m_rca = '0;
         m_spi = 1'b0;
         m_ce = 1'b0;
         q.delete();
      end else begin
         m_ce = ce;
         if (ce) begin
            m_spi = spi_mode;
            if (cmd_rx && !spi_mode && !cmd_crc_bad && !cmd_illegal) begin
               w = m_stk | place(cev);
               w = w | {8'h00, m_crc, m_ill, 7'h00, ecc_off, 1'b0, card_state, buf_ready, 8'h00};
               q.push_back(w);
               m_stk = '0;
            end
            // prior command only, any received command replaces them
            if (cmd_rx) begin
               m_crc = cmd_crc_bad;
               m_ill = !cmd_crc_bad && cmd_illegal;
            end
            m_stk = m_stk | place(xev);
            if (rca_load) begin
               m_rca = rca_in;
            end
         end
      end
   end
   // ****************************************
   // output watcher
   // ****************************************
   always @(negedge clk) begin
      `CHK(rca_out, m_spi ? 16'h0000 : m_rca)
      if (resp_valid === 1'b1 && m_ce === 1'b1) begin
         if (q.size() == 0) begin
            `CHK(resp_valid, 1'b0)
         end else begin
            g = q.pop_front();
            `CHK(resp_word[31:28], g[31:28])
            `CHK(resp_word[27:24], g[27:24])
            `CHK(resp_word[23:16], g[23:16])
            `CHK(resp_word[15:13], g[15:13])
            `CHK(resp_word[12:8], g[12:8])
            `CHK(resp_word[7:0], g[7:0])
         end
      end
   end
   // ****************************************
   // clock, watchdog, stimulus
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      finish_test();
   end
   initial begin
      {rst_b, spi_mode, go, crc, ill, ecc_off, buf_ready, rca_load} = '0;
      {ev, xev, card_state, rca_in} = '0;
      ce = 1'b1;
      mismatches = 0;
      compares = 0;
      void'($urandom(44406));
      repeat (16) @(posedge clk);
      #2;
      rst_b = 1'b1;
      for (int n = 0; n < 600; n++) begin
         if (n == 300) begin
            rst_b = 1'b0;
            @(posedge clk);
            #2;
            rst_b = 1'b1;
         end
         if (n == 500) spi_mode = 1'b1;
         ce = ($urandom % 8) != 0;
         go = ($urandom % 3) != 0;
         crc = ($urandom % 8) == 0 && !spi_mode;
         ill = ($urandom % 8) == 0 && !spi_mode;
         ev = CSR_FLAG_N'($urandom & $urandom & $urandom);
         xev = spi_mode ? '0 : CSR_FLAG_N'($urandom & $urandom & $urandom);
         card_state = CSR_STATE_W'($urandom % 9);
         ecc_off = 1'($urandom);
         buf_ready = 1'($urandom);
         rca_load = ($urandom % 16) == 0;
         rca_in = CSR_RCA_W'($urandom);
         @(posedge clk);
         #2;
      end
      go = 1'b0;
      repeat (3) @(posedge clk);
      `CHK(q.size(), 0)
      finish_test();
   end
endmodule

// ==== verification/csr_host.sv ====
// host side model driving the command strobe and its qualifiers
module csr_host
   import csr_pkg::*;
(
   input wire logic go,
   input wire logic crc_i,
   input wire logic ill_i,
   input wire logic [CSR_FLAG_N-1:0] ev_i,
   output logic cmd_rx,
   output logic cmd_crc_bad,
   output logic cmd_illegal,
   output logic [CSR_FLAG_N-1:0] cmd_err_ev
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // command and status poll strobe
   // ****************************************
   assign cmd_rx = go;
   // qualifiers scrambled while no command is offered
   assign cmd_crc_bad = go ? crc_i : ~crc_i;
   assign cmd_illegal = go ? ill_i : ~ill_i;
   assign cmd_err_ev = go ? ev_i : ~ev_i;
endmodule
